// ==== ecp_cfg_prot.sv ====
// EEPROM configuration, timebase and protection with a Wishbone slave
`timescale 1ns/100ps
`include "ecp_consts.svh"
module ecp_cfg_prot
    import ecp_pkg::*;
#(
    parameter int DIV_W    = 16,
    parameter int OP_TICKS = `ECP_OP_TICKS
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave, 8 bit data
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [0:0]  wb_sel_i,
    input  wire logic [7:0]  wb_dat_i,
    output logic      [7:0]  wb_dat_o,
    output logic             wb_ack_o,
    // Oscillator reference pin
    input  wire logic        osc_ref_i,
    // Status
    output logic             busy_o
);

    // Array and nonvolatile bytes keep their contents over reset
    logic [7:0] mem [0:`ECP_ARR_BYTES-1] = '{default: `ECP_ERASED};
    logic [7:0] nv_cfg  = `ECP_ERASED;
    logic [7:0] nv_divh = `ECP_ERASED;
    logic [7:0] nv_divl = `ECP_ERASED;

    // Volatile copies
    logic [7:0] acr;
    logic [7:0] divh;
    logic [7:0] divl;

    // Control state
    logic       pgm;
    logic       lat;
    ecp_mode_t  mode;
    logic       clksel;
    logic       avalid;
    logic       refused;
    logic [15:0] lat_adr;
    logic [7:0] lat_dat;
    logic [7:0] op_cnt;

    // Decode and datapath
    logic       wb_req;
    logic       wb_fire;
    logic       wr_fire;
    logic       rd_fire;
    logic       rd_eep;
    logic       wr_eep;
    logic       ctrl_wr;
    logic       secured;
    logic       dlocked;
    logic       tick;
    logic       op_done;
    logic       blocked;
    logic       in_sec;
    logic [1:0] blk;
    logic [8:0] off;
    ecp_tgt_t   tgt;
    logic [7:0] next_rd;
    logic [DIV_W-1:0] div_val;

    function automatic ecp_tgt_t classify(input logic [15:0] a);
        if (a >= `ECP_ARR_BASE && a <= `ECP_ARR_LAST) begin
            return ECP_TGT_ARRAY;
        end else if (a == `ECP_NVCFG_ADR) begin
            return ECP_TGT_NVCFG;
        end else if (a == `ECP_NVDIVH_ADR) begin
            return ECP_TGT_NVDIVH;
        end else if (a == `ECP_NVDIVL_ADR) begin
            return ECP_TGT_NVDIVL;
        end
        return ECP_TGT_NONE;
    endfunction

    assign wb_req  = wb_cyc_i && wb_stb_i;
    assign wb_fire = wb_req && wb_ack_o;
    assign wr_fire = wb_fire && wb_we_i && wb_sel_i[0];
    assign rd_fire = wb_fire && !wb_we_i;
    assign wr_eep  = wr_fire && classify(wb_adr_i) != ECP_TGT_NONE;
    assign rd_eep  = rd_fire && classify(wb_adr_i) != ECP_TGT_NONE;
    assign ctrl_wr = wr_fire && wb_adr_i == `ECP_CTRL_ADR;

    assign secured = !nv_cfg[`ECP_SEC_BIT];
    assign dlocked = !divh[`ECP_DLOCK_BIT];
    assign busy_o  = pgm;

    // Bus answer: ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
        end
    end

    always_comb begin
        next_rd = `ECP_ZERO;
        if (lat && avalid && classify(wb_adr_i) != ECP_TGT_NONE) begin
            next_rd = lat_dat;
        end else begin
            case (classify(wb_adr_i))
                ECP_TGT_ARRAY:  next_rd = mem[wb_adr_i[8:0]];
                ECP_TGT_NVCFG:  next_rd = nv_cfg;
                ECP_TGT_NVDIVH: next_rd = nv_divh;
                ECP_TGT_NVDIVL: next_rd = nv_divl;
                default: begin
                    case (wb_adr_i)
                        `ECP_CTRL_ADR: next_rd = {1'b0, refused, avalid, clksel,
                                                  mode, lat, pgm};
                        `ECP_ACR_ADR:  next_rd = acr;
                        `ECP_DIVH_ADR: next_rd = divh;
                        `ECP_DIVL_ADR: next_rd = divl;
                        default:       next_rd = `ECP_ZERO;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `ECP_ZERO;
        end else if (wb_req && !wb_ack_o) begin
            wb_dat_o <= next_rd;
        end
    end

    // Volatile configuration copy; protection follows only reset or a
    // read of the nonvolatile byte, never a direct write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acr <= nv_cfg;
        end else if (rd_fire && wb_adr_i == `ECP_NVCFG_ADR) begin
            acr <= nv_cfg;
        end
    end

    // Divider registers; a zero lock bit in the source reloads as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divh <= nv_divh;
            divl <= nv_divl;
        end else if (wr_fire && !dlocked) begin
            if (wb_adr_i == `ECP_DIVH_ADR) begin
                divh <= wb_dat_i;
            end
            if (wb_adr_i == `ECP_DIVL_ADR) begin
                divl <= wb_dat_i;
            end
        end
    end

    // Lock bit is not part of the count
    assign div_val = DIV_W'({divh[`ECP_DLOCK_BIT-1:0], divl});

    ecp_tick_div #(
        .DIV_W (DIV_W)
    ) u_tick (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clk_sel_i (clksel),
        .ref_i     (osc_ref_i),
        .div_i     (div_val),
        .tick_o    (tick)
    );

    // Control register; while running only the start bit may change,
    // so clearing start and latch together clears start alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pgm    <= 1'b0;
            lat    <= 1'b0;
            mode   <= ECP_PROG;
            clksel <= 1'b0;
        end else if (op_done) begin
            pgm <= 1'b0;
        end else if (ctrl_wr) begin
            if (pgm) begin
                pgm <= wb_dat_i[`ECP_CTRL_PGM];
            end else begin
                pgm    <= wb_dat_i[`ECP_CTRL_PGM] && lat && avalid;
                lat    <= wb_dat_i[`ECP_CTRL_LAT];
                mode   <= ecp_mode_t'(wb_dat_i[`ECP_CTRL_MODE +: 2]);
                clksel <= wb_dat_i[`ECP_CTRL_CLKSEL];
            end
        end
    end

    // Address and data latch; the last valid access wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avalid  <= 1'b0;
            lat_adr <= 16'h0000;
            lat_dat <= `ECP_ZERO;
        end else if (!lat) begin
            avalid <= 1'b0;
        end else if (!pgm && wr_eep) begin
            avalid  <= 1'b1;
            lat_adr <= wb_adr_i;
            lat_dat <= wb_dat_i;
        end else if (!pgm && rd_eep && avalid) begin
            lat_adr <= wb_adr_i;
        end
    end

    // Operation timer counts ticks while the start bit is set
    always_ff @(posedge clk_i) begin
        if (rst_i || !pgm) begin
            op_cnt <= `ECP_ZERO;
        end else if (tick) begin
            op_cnt <= op_cnt + 8'h01;
        end
    end

    assign op_done = pgm && tick && op_cnt == 8'(OP_TICKS - 1);

    // Protection decision for the latched target
    assign tgt    = classify(lat_adr);
    assign off    = lat_adr[8:0];
    assign blk    = lat_adr[8:7];
    assign in_sec = lat_adr >= `ECP_SEC_FIRST && lat_adr <= `ECP_SEC_LAST;

    always_comb begin
        blocked = 1'b1;
        case (tgt)
            ECP_TGT_NVCFG: begin
                blocked = secured;
            end
            ECP_TGT_NVDIVH, ECP_TGT_NVDIVL: begin
                blocked = dlocked;
            end
            ECP_TGT_ARRAY: begin
                case (mode)
                    ECP_BLK_ER:  blocked = secured || acr[blk];
                    ECP_BULK_ER: blocked = secured || |acr[3:0];
                    default:     blocked = (secured && in_sec) || acr[blk];
                endcase
            end
            default: begin
                blocked = 1'b1;
            end
        endcase
    end

    // Refused operations still finish and clear the start bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refused <= 1'b0;
        end else if (op_done) begin
            refused <= blocked;
        end
    end

    // Array cells; programming only clears bits, erase sets the byte
    for (genvar i = 0; i < `ECP_ARR_BYTES; i++) begin : g_cell
        logic hit;
        assign hit = (mode == ECP_BULK_ER)
                  || (mode == ECP_BLK_ER && 2'(i >> 7) == blk)
                  || (9'(i) == off);
        always_ff @(posedge clk_i) begin
            if (op_done && !blocked && tgt == ECP_TGT_ARRAY && hit) begin
                if (mode == ECP_PROG) begin
                    mem[i] <= mem[i] & lat_dat;
                end else begin
                    mem[i] <= `ECP_ERASED;
                end
            end
        end
    end

    // Nonvolatile configuration and divider bytes
    always_ff @(posedge clk_i) begin
        if (op_done && !blocked) begin
            case (tgt)
                ECP_TGT_NVCFG: begin
                    nv_cfg <= (mode == ECP_PROG) ? nv_cfg & lat_dat : `ECP_ERASED;
                end
                ECP_TGT_NVDIVH: begin
                    nv_divh <= (mode == ECP_PROG) ? nv_divh & lat_dat : `ECP_ERASED;
                end
                ECP_TGT_NVDIVL: begin
                    nv_divl <= (mode == ECP_PROG) ? nv_divl & lat_dat : `ECP_ERASED;
                end
                default: begin
                    nv_cfg <= nv_cfg;
                end
            endcase
        end
    end

    // Checks

    ack_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o
    ) else $error("ack held for more than one cycle");

    start_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(pgm) |-> $past(lat) && $past(avalid)
    ) else $error("start set without latch and valid address");

    reset_load_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> acr == nv_cfg && divh == nv_divh && divl == nv_divl
    ) else $error("volatile copies not loaded at reset");

    prot_reload_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(rd_fire && wb_adr_i == `ECP_NVCFG_ADR) |=> $stable(acr)
    ) else $error("protection changed without reset or config read");

    cfg_frozen_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        secured |=> $stable(nv_cfg)
    ) else $error("config byte changed while secured");

    sec_region_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        secured |=> $stable(mem[9'h0F0]) && $stable(mem[9'h0FF])
    ) else $error("secured region altered");

    div_lock_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        dlocked |=> $stable(divl) && $stable(nv_divh) && $stable(nv_divl)
    ) else $error("divider changed while locked");

    wide_erase_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        op_done && secured && tgt == ECP_TGT_ARRAY && mode inside {ECP_BLK_ER, ECP_BULK_ER}
        |=> refused && !pgm
    ) else $error("wide erase not refused while secured");

    byte_ok_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        op_done && tgt == ECP_TGT_ARRAY && mode == ECP_BYTE_ER && !in_sec && !acr[blk]
        |=> !refused && mem[$past(off)] == `ECP_ERASED
    ) else $error("allowed byte erase did not take effect");

endmodule

// ==== ecp_cfg_prot_tb.sv ====
// Self-checking bench for the EEPROM configuration and protection block
`timescale 1ns/100ps
`include "ecp_consts.svh"
module ecp_cfg_prot_tb;
    import ecp_pkg::*;
    // Short operation keeps each program/erase to a few ticks
    localparam int OPT = 2;
    logic        clk_i;
    logic        rst_i     = 1'b1;
    logic        osc_ref_i = 1'b0;
    logic        osc_ph    = 1'b0;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [0:0]  sel;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    logic        ack;
    logic        busy_o;
    logic        csel      = 1'b0;
    int          err_total = 0;
    int          checks_done = 0;

    ecp_cfg_prot #(.OP_TICKS(OPT)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .osc_ref_i(osc_ref_i), .busy_o(busy_o)
    );

    ecp_cpu_model i_cpu (
        .clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
        .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Reference pin at a quarter of the bus clock
    always @(posedge clk_i) begin
        osc_ph <= ~osc_ph;
        if (osc_ph) begin
            osc_ref_i <= ~osc_ref_i;
        end
    end

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_cpu.access(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
        logic [7:0] r;
        i_cpu.access(1'b0, a, 8'h00, r);
        check(what, exp, r);
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // Full latch, target, start sequence; judges run time and the refused flag
    task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [1:0] m,
                      input logic refd);
        int         n;
        logic [7:0] c;
        logic [7:0] r;
        c = {3'b000, csel, m, 2'b10};
        wr(`ECP_CTRL_ADR, c);
        wr(a, d);
        wr(`ECP_CTRL_ADR, c | 8'h01);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (busy_o === 1'b1 && n < 300);
        check("busy span in range", 8'h01,
              {7'b0, csel ? (n >= 8 && n <= 26) : (n >= 2 && n <= 7)});
        i_cpu.access(1'b0, `ECP_CTRL_ADR, 8'h00, r);
        check("refused flag", {7'b0, refd}, {7'b0, r[`ECP_CTRL_REFUSED]});
        wr(`ECP_CTRL_ADR, 8'h00);
    endtask

    task automatic t_defaults();
        rd_chk(`ECP_ACR_ADR, `ECP_ERASED, "array config at reset");
        rd_chk(`ECP_DIVH_ADR, `ECP_ERASED, "divider high at reset");
        rd_chk(`ECP_DIVL_ADR, `ECP_ERASED, "divider low at reset");
        rd_chk(`ECP_ARR_BASE, `ECP_ERASED, "first array byte");
        wr(16'h0A00, 8'h12);
        rd_chk(16'h0A00, `ECP_ZERO, "byte past the array");
        // Bit 7 kept at one, else the divider would lock itself
        wr(`ECP_DIVH_ADR, 8'h80);
        wr(`ECP_DIVL_ADR, 8'h02);
        rd_chk(`ECP_DIVL_ADR, 8'h02, "divider low written");
    endtask

    // Busy is looked at half a cycle after the ack edge, once it has settled
    task automatic t_start_gate();
        wr(`ECP_CTRL_ADR, 8'h01);
        @(negedge clk_i);
        check("start without latch", 8'h00, {7'b0, busy_o});
        wr(`ECP_CTRL_ADR, 8'h02);
        wr(`ECP_CTRL_ADR, 8'h03);
        @(negedge clk_i);
        check("start without address", 8'h00, {7'b0, busy_o});
        rd_chk(`ECP_CTRL_ADR, 8'h02, "control after gated start");
        wr(`ECP_CTRL_ADR, 8'h00);
    endtask

    task automatic t_protect();
        op(`ECP_ARR_BASE, 8'h5A, 2'd0, 1'b1);
        rd_chk(`ECP_ARR_BASE, `ECP_ERASED, "protected byte kept");
        op(`ECP_NVCFG_ADR, 8'hF0, 2'd0, 1'b0);
        op(`ECP_ARR_BASE, 8'h5A, 2'd0, 1'b1);
        rd_chk(`ECP_NVCFG_ADR, 8'hF0, "config byte");
        rd_chk(`ECP_ACR_ADR, 8'hF0, "array config copy");
        op(`ECP_ARR_BASE, 8'h5A, 2'd0, 1'b0);
        rd_chk(`ECP_ARR_BASE, 8'h5A, "programmed byte");
        op(`ECP_ARR_BASE, 8'h00, 2'd1, 1'b0);
        rd_chk(`ECP_ARR_BASE, `ECP_ERASED, "erased byte");
        op(`ECP_ARR_BASE, 8'hA5, 2'd0, 1'b0);
        op(16'h0840, 8'h00, 2'd2, 1'b0);
        rd_chk(`ECP_ARR_BASE, `ECP_ERASED, "block erased byte");
        op(`ECP_ARR_LAST, 8'h3C, 2'd0, 1'b0);
        rd_chk(`ECP_ARR_LAST, 8'h3C, "last array byte");
        op(`ECP_NVCFG_ADR, 8'h00, 2'd1, 1'b0);
        op(`ECP_NVCFG_ADR, 8'hF4, 2'd0, 1'b0);
        rd_chk(`ECP_NVCFG_ADR, 8'hF4, "config byte block two");
        op(16'h097F, 8'h11, 2'd0, 1'b1);
        rd_chk(16'h097F, `ECP_ERASED, "block two top kept");
        op(16'h0980, 8'h22, 2'd0, 1'b0);
        rd_chk(16'h0980, 8'h22, "block three base");
        csel = 1'b1;
        op(16'h08F5, 8'h33, 2'd0, 1'b0);
        csel = 1'b0;
        rd_chk(16'h08F5, 8'h33, "byte on reference clock");
    endtask

    task automatic t_security();
        op(`ECP_NVCFG_ADR, 8'h74, 2'd0, 1'b0);
        rd_chk(`ECP_NVCFG_ADR, 8'h74, "armed config byte");
        op(`ECP_SEC_FIRST, 8'h00, 2'd0, 1'b1);
        rd_chk(`ECP_SEC_FIRST, `ECP_ERASED, "secured byte kept");
        op(`ECP_SEC_LAST, 8'h00, 2'd0, 1'b1);
        op(16'h08F5, 8'h00, 2'd1, 1'b1);
        rd_chk(16'h08F5, 8'h33, "secured byte readable");
        op(`ECP_NVCFG_ADR, 8'h00, 2'd1, 1'b1);
        rd_chk(`ECP_NVCFG_ADR, 8'h74, "config byte frozen");
        op(16'h0801, 8'h0F, 2'd0, 1'b0);
        op(16'h08EF, 8'h44, 2'd0, 1'b0);
        rd_chk(16'h08EF, 8'h44, "unsecured edge byte");
        op(16'h0801, 8'h00, 2'd2, 1'b1);
        op(16'h0801, 8'h00, 2'd3, 1'b1);
        rd_chk(16'h0801, 8'h0F, "byte after erase refusals");
        rd_chk(`ECP_ARR_LAST, 8'h3C, "last byte after bulk refusal");
    endtask

    task automatic t_div_lock();
        op(`ECP_NVDIVL_ADR, 8'h02, 2'd0, 1'b0);
        op(`ECP_NVDIVH_ADR, 8'h00, 2'd0, 1'b0);
        do_reset();
        rd_chk(`ECP_ACR_ADR, 8'h74, "config copy after reset");
        rd_chk(`ECP_DIVH_ADR, 8'h00, "locked divider high");
        rd_chk(`ECP_DIVL_ADR, 8'h02, "divider low loaded");
        wr(`ECP_DIVH_ADR, 8'h80);
        wr(`ECP_DIVL_ADR, 8'h05);
        rd_chk(`ECP_DIVH_ADR, 8'h00, "divider high write ignored");
        rd_chk(`ECP_DIVL_ADR, 8'h02, "divider low write ignored");
        op(`ECP_NVDIVH_ADR, 8'h00, 2'd1, 1'b1);
        op(`ECP_NVDIVL_ADR, 8'h00, 2'd1, 1'b1);
        rd_chk(`ECP_NVDIVH_ADR, 8'h00, "nv divider high kept");
        rd_chk(`ECP_NVDIVL_ADR, 8'h02, "nv divider low kept");
        do_reset();
        rd_chk(`ECP_DIVH_ADR, 8'h00, "divider high second reset");
    endtask

    // A full run needs under a thousand cycles; this leaves ample margin
    initial begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        complete_run();
    end

    initial begin
        do_reset();
        t_defaults();
        t_start_gate();
        t_protect();
        t_security();
        t_div_lock();
        complete_run();
    end
endmodule

// ==== ecp_consts.svh ====
// Constants for the EEPROM configuration and protection block
//
// Functional notes
// - 512 byte array from 0800 to 09FF
// - Reset copies nonvolatile bytes into volatile registers
// - Config byte feeds array config; divider bytes feed divider
// - 35 us tick from selected reference divide
// - Security blocks program/erase of 08F0 to 08FF
// - Secured region stays readable
// - Security blocks program/erase of config byte
// - Security is permanent; config byte frozen
// - Security rejects block and bulk erase
// - Security still allows unprotected single byte operations
// - Four 128 byte blocks, each with protect bit
// - Protect bits act after reset or config read
// - Programmed divider lock bit reloads as zero
// - Divider lock blocks divider updates
// - Start bit needs latch enable and valid address
`ifndef ECP_CONSTS_SVH
`define ECP_CONSTS_SVH

// Address map, byte addressed
`define ECP_ARR_BASE     16'h0800
`define ECP_ARR_LAST     16'h09FF
`define ECP_ARR_BYTES    512
`define ECP_SEC_FIRST    16'h08F0
`define ECP_SEC_LAST     16'h08FF
`define ECP_CTRL_ADR     16'h0060
`define ECP_ACR_ADR      16'h0061
`define ECP_DIVH_ADR     16'h0062
`define ECP_DIVL_ADR     16'h0063
`define ECP_NVCFG_ADR    16'h0064
`define ECP_NVDIVH_ADR   16'h0065
`define ECP_NVDIVL_ADR   16'h0066

// Field positions
`define ECP_SEC_BIT      7
`define ECP_DLOCK_BIT    7
`define ECP_CTRL_PGM     0
`define ECP_CTRL_LAT     1
`define ECP_CTRL_MODE    2
`define ECP_CTRL_CLKSEL  4
`define ECP_CTRL_AVALID  5
`define ECP_CTRL_REFUSED 6

// Reset and erased values
`define ECP_ERASED       8'hFF
`define ECP_ZERO         8'h00

// Timing
`define ECP_TICK_US      35
`define ECP_OP_TICKS     8

`endif

// ==== ecp_cpu_model.sv ====
// Bus master model standing in for the CPU core on the memory bus
`timescale 1ns/100ps
module ecp_cpu_model (
    // Clock
    input  wire logic        clk_i,
    // Wishbone master side
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [15:0]      wb_adr_o,
    output logic [0:0]       wb_sel_o,
    output logic [7:0]       wb_dat_o,
    input  wire logic [7:0]  wb_dat_i,
    input  wire logic        wb_ack_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 16'h0000;
        wb_sel_o = 1'b1;
        wb_dat_o = 8'h00;
    end

    // One classic cycle; no own limit on the wait, the bench watchdog ends a hang
    task automatic access(input logic we, input logic [15:0] adr, input logic [7:0] wd,
                          output logic [7:0] rd);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_dat_o <= wd;
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        rd = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // Released lines flip so a stale value never passes for a live one
        wb_we_o  <= ~we;
        wb_adr_o <= ~adr;
        wb_dat_o <= ~wd;
    endtask
endmodule

// ==== ecp_pkg.sv ====
// Types for the EEPROM configuration and protection block
package ecp_pkg;

    // Operation selected by the two mode bits of the control register
    typedef enum logic [1:0] {
        ECP_PROG,
        ECP_BYTE_ER,
        ECP_BLK_ER,
        ECP_BULK_ER
    } ecp_mode_t;

    // What the latched address points at
    typedef enum logic [2:0] {
        ECP_TGT_NONE,
        ECP_TGT_ARRAY,
        ECP_TGT_NVCFG,
        ECP_TGT_NVDIVH,
        ECP_TGT_NVDIVL
    } ecp_tgt_t;

endpackage

// ==== ecp_tick_div.sv ====
// Timebase divider producing the program/erase tick
`timescale 1ns/100ps
module ecp_tick_div
    import ecp_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Reference selection and divider
    input  wire logic             clk_sel_i,
    input  wire logic             ref_i,
    input  wire logic [DIV_W-1:0] div_i,
    // Tick
    output logic                  tick_o
);

    logic             ref_s1;
    logic             ref_s2;
    logic             ref_s3;
    logic             ref_lvl;
    logic             ref_edge;
    logic             step;
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;

    always_ff @(posedge clk_i) begin
        ref_s1 <= ref_i;
        ref_s2 <= ref_s1;
        ref_s3 <= ref_s2;
    end

    // A rising level change counts only once two stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Take the pin's present level so no false edge follows reset
            ref_lvl <= ref_s3;
        end else if (ref_s2 == ref_s3) begin
            ref_lvl <= ref_s3;
        end
    end

    assign ref_edge = (ref_s2 == ref_s3) && ref_s3 && !ref_lvl;
    assign step     = clk_sel_i ? ref_edge : 1'b1;
    assign next_cnt = cnt + {{(DIV_W-1){1'b0}}, 1'b1};

    // A zero divider stops the tick rather than running flat out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else if (step && div_i != '0 && next_cnt >= div_i) begin
            cnt    <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt    <= step ? next_cnt : cnt;
            tick_o <= 1'b0;
        end
    end

    tick_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        tick_o && div_i > 1 && $stable(div_i) |=> !tick_o
    ) else $error("tick lasted more than one cycle");

endmodule
